/* inc/csl_pkg.sv */
/*
 * Package for the clock stop and strap latch block: clock divider counts,
 * power-up timer, strap layout and packed carriers.
 * Assumes a single 100 MHz system clock that all derived clocks come from.
 */
package csl_pkg;

	localparam int CLK_SYS_MHZ = 100;

	// Half periods, in system cycles, of the derived clock groups
	localparam logic [7:0] CPU_HALF_CYC = 8'h01;
	localparam logic [7:0] PCI_HALF_CYC = 8'h02;
	localparam logic [7:0] DUAL_HALF_CYC = 8'h04;

	localparam int PCI_OUT_NUM = 6;
	localparam int CPU_OUT_NUM = 4;
	localparam int STRAP_NUM = 5;

	// Power-up timer: the bound in microseconds and its cycle count
	localparam int PWRUP_US = 3000;
	localparam int PWRUP_CYC = PWRUP_US * CLK_SYS_MHZ;

	// System cycles allowed for the pins to settle after reset release
	localparam logic [3:0] STRAP_SETTLE_CYC = 4'h4;

	localparam logic [STRAP_NUM-1:0] STRAP_RST = 5'h00;

	typedef enum logic [1:0] {
		CSL_ST_SETTLE = 2'b00,
		CSL_ST_LOW = 2'b01,
		CSL_ST_RUN = 2'b10
	} csl_state_t;

	typedef struct packed {
		logic halt_n;
		logic grp_clk;
	} csl_gate_in_t;

	typedef struct packed {
		logic [CPU_OUT_NUM-1:0] cpu_clk;
		logic [PCI_OUT_NUM-1:0] pci_clk;
		logic free_pci_clk;
	} csl_clk_out_t;

endpackage

/* src/csl_clk_gate.sv */
/*
 * Glitch-free gate for one clock group: resynchronises an active-low halt
 * request and changes the gate only while the group clock is low.
 * Assumes grp_clk is a register output toggling on clk_sys_i.
 */
`timescale 1ns/10ps
module csl_clk_gate
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire csl_pkg::csl_gate_in_t gate_i,
	input wire logic fall_ena_i,
	output logic run_o
);

	logic sync1_r;
	logic sync1_nxt;
	logic run_r;
	logic run_nxt;

	// ----------------------------------------
	// Resync and low-phase gate update
	// ----------------------------------------
	always_comb
	begin
		sync1_nxt = gate_i.halt_n;
		run_nxt = run_r;
		// Update only on the edge that starts a low phase, so the next high
		// phase is either full or absent and the current one is never cut
		if (fall_ena_i && gate_i.grp_clk)
		begin
			run_nxt = sync1_r;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			sync1_r <= 1'b1;
			run_r <= 1'b1;
		end
		else
		begin
			sync1_r <= sync1_nxt;
			run_r <= run_nxt;
		end
	end

	assign run_o = run_r;

endmodule

/* src/csl_top.sv */
/*
 * Clock stop control and power-up strap latch. Generates CPU, PCI and
 * dual-function clocks from one system clock, halts the CPU and PCI groups
 * on request, latches five straps once after power-on.
 * Assumes halt inputs change on the rising edge of the free PCI clock.
 */
`timescale 1ns/10ps
module csl_top
#(
	parameter int PWRUP_CYC = csl_pkg::PWRUP_CYC
)
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic cpu_halt_n_i,
	input wire logic pci_halt_n_i,
	input wire logic [csl_pkg::STRAP_NUM-1:0] dual_pin_i,
	output logic [csl_pkg::STRAP_NUM-1:0] dual_pin_o,
	output logic [csl_pkg::STRAP_NUM-1:0] dual_pin_oe_o,
	output logic [csl_pkg::STRAP_NUM-1:0] strap_cfg_o,
	output logic strap_valid_o,
	output csl_pkg::csl_clk_out_t clk_out_o
);

	// ----------------------------------------
	// Clock dividers
	// ----------------------------------------
	// Both dividers leave reset on the same edge, so the group phases keep a
	// fixed relation to each other and to the free PCI clock
	function automatic logic [7:0] csl_cnt_next(input logic [7:0] cnt, input logic [7:0] half);
		csl_cnt_next = (cnt == half - 8'h01) ? 8'h00 : cnt + 8'h01;
	endfunction

	function automatic logic csl_cnt_wrap(input logic [7:0] cnt, input logic [7:0] half);
		csl_cnt_wrap = (cnt == half - 8'h01);
	endfunction

	logic [7:0] cpu_cnt_r;
	logic [7:0] cpu_cnt_nxt;
	logic [7:0] pci_cnt_r;
	logic [7:0] pci_cnt_nxt;
	logic cpu_ph_r;
	logic cpu_ph_nxt;
	logic pci_ph_r;
	logic pci_ph_nxt;
	logic cpu_tgl;
	logic pci_tgl;

	always_comb
	begin
		cpu_tgl = csl_cnt_wrap(cpu_cnt_r, csl_pkg::CPU_HALF_CYC);
		pci_tgl = csl_cnt_wrap(pci_cnt_r, csl_pkg::PCI_HALF_CYC);
		cpu_cnt_nxt = csl_cnt_next(cpu_cnt_r, csl_pkg::CPU_HALF_CYC);
		pci_cnt_nxt = csl_cnt_next(pci_cnt_r, csl_pkg::PCI_HALF_CYC);
		cpu_ph_nxt = cpu_tgl ? ~cpu_ph_r : cpu_ph_r;
		pci_ph_nxt = pci_tgl ? ~pci_ph_r : pci_ph_r;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			cpu_cnt_r <= 8'h00;
			pci_cnt_r <= 8'h00;
			cpu_ph_r <= 1'b0;
			pci_ph_r <= 1'b0;
		end
		else
		begin
			cpu_cnt_r <= cpu_cnt_nxt;
			pci_cnt_r <= pci_cnt_nxt;
			cpu_ph_r <= cpu_ph_nxt;
			pci_ph_r <= pci_ph_nxt;
		end
	end

	// ----------------------------------------
	// Group gates
	// ----------------------------------------
	// A gate decision is taken on the cycle before a falling edge of the phase
	logic cpu_run;
	logic pci_run;
	csl_pkg::csl_gate_in_t cpu_gate_in;
	csl_pkg::csl_gate_in_t pci_gate_in;

	assign cpu_gate_in = '{halt_n: cpu_halt_n_i, grp_clk: cpu_ph_r};
	assign pci_gate_in = '{halt_n: pci_halt_n_i, grp_clk: pci_ph_r};

	// Halt inputs are launched on the free PCI clock edge, which is a clk_sys_i
	// edge here, so one register stage is safe. A second stage would push the
	// PCI group past its one-period stop and restart bound; an input that is
	// not launched this way would need the extra stage and lose that bound.
	csl_clk_gate u_cpu_gate
	(
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.gate_i(cpu_gate_in),
		.fall_ena_i(cpu_tgl),
		.run_o(cpu_run)
	);

	csl_clk_gate u_pci_gate
	(
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.gate_i(pci_gate_in),
		.fall_ena_i(pci_tgl),
		.run_o(pci_run)
	);

	// ----------------------------------------
	// State decodes
	// ----------------------------------------
	// Shared by the pin enables, the valid flag and the dual divider
	function automatic logic csl_latched(input csl_pkg::csl_state_t st);
		csl_latched = (st != csl_pkg::CSL_ST_SETTLE);
	endfunction

	function automatic logic csl_running(input csl_pkg::csl_state_t st);
		csl_running = (st == csl_pkg::CSL_ST_RUN);
	endfunction

	// ----------------------------------------
	// Strap latch and power-up timer
	// ----------------------------------------
	// Settle: pins are inputs, waiting for their levels to stand still
	// Low: straps held, pins driven low while the power-up timer runs
	// Run: pins toggle at the dual clock rate; the straps stay frozen
	// A reset is taken as a new power-on and captures the straps again
	csl_pkg::csl_state_t st_r;
	csl_pkg::csl_state_t st_nxt;
	logic [3:0] settle_r;
	logic [3:0] settle_nxt;
	logic [31:0] pwr_cnt_r;
	logic [31:0] pwr_cnt_nxt;
	logic [csl_pkg::STRAP_NUM-1:0] strap_r;
	logic [csl_pkg::STRAP_NUM-1:0] strap_nxt;
	logic [7:0] dual_cnt_r;
	logic [7:0] dual_cnt_nxt;
	logic dual_ph_r;
	logic dual_ph_nxt;

	always_comb
	begin
		st_nxt = st_r;
		settle_nxt = settle_r;
		pwr_cnt_nxt = pwr_cnt_r;
		strap_nxt = strap_r;
		case (st_r)
			csl_pkg::CSL_ST_SETTLE:
			begin
				// Reset release stands for the supply reaching its latch level
				if (settle_r == csl_pkg::STRAP_SETTLE_CYC - 4'h1)
				begin
					strap_nxt = dual_pin_i;
					st_nxt = csl_pkg::CSL_ST_LOW;
				end
				else
				begin
					settle_nxt = settle_r + 4'h1;
				end
			end
			csl_pkg::CSL_ST_LOW:
			begin
				if (pwr_cnt_r == 32'(PWRUP_CYC - 1))
				begin
					st_nxt = csl_pkg::CSL_ST_RUN;
				end
				else
				begin
					pwr_cnt_nxt = pwr_cnt_r + 32'h00000001;
				end
			end
			csl_pkg::CSL_ST_RUN:
			begin
				// Straps are never re-sampled here
				strap_nxt = strap_r;
			end
			default:
			begin
				st_nxt = csl_pkg::CSL_ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			st_r <= csl_pkg::CSL_ST_SETTLE;
			settle_r <= 4'h0;
			pwr_cnt_r <= 32'h00000000;
			strap_r <= csl_pkg::STRAP_RST;
		end
		else
		begin
			st_r <= st_nxt;
			settle_r <= settle_nxt;
			pwr_cnt_r <= pwr_cnt_nxt;
			strap_r <= strap_nxt;
		end
	end

	// ----------------------------------------
	// Dual-function pin divider
	// ----------------------------------------
	// Held at its reset phase until the timer has run out, so the first
	// high phase on the pins is a full one
	always_comb
	begin
		dual_cnt_nxt = dual_cnt_r;
		dual_ph_nxt = dual_ph_r;
		if (csl_running(st_r))
		begin
			dual_cnt_nxt = csl_cnt_next(dual_cnt_r, csl_pkg::DUAL_HALF_CYC);
			if (csl_cnt_wrap(dual_cnt_r, csl_pkg::DUAL_HALF_CYC))
			begin
				dual_ph_nxt = ~dual_ph_r;
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			dual_cnt_r <= 8'h00;
			dual_ph_r <= 1'b0;
		end
		else
		begin
			dual_cnt_r <= dual_cnt_nxt;
			dual_ph_r <= dual_ph_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Pin enable and value come from the next state, so both change on the
	// same edge and the pins never show a stray level in between
	logic [csl_pkg::STRAP_NUM-1:0] dual_oe_r;
	logic [csl_pkg::STRAP_NUM-1:0] dual_oe_nxt;
	logic [csl_pkg::STRAP_NUM-1:0] dual_out_r;
	logic [csl_pkg::STRAP_NUM-1:0] dual_out_nxt;
	logic strap_valid_r;
	logic strap_valid_nxt;
	csl_pkg::csl_clk_out_t clk_r;
	csl_pkg::csl_clk_out_t clk_nxt;

	always_comb
	begin
		// Parked groups hold low; the free clock is never gated
		clk_nxt.cpu_clk = {csl_pkg::CPU_OUT_NUM{cpu_ph_nxt & cpu_run}};
		clk_nxt.pci_clk = {csl_pkg::PCI_OUT_NUM{pci_ph_nxt & pci_run}};
		clk_nxt.free_pci_clk = pci_ph_nxt;
		strap_valid_nxt = csl_latched(st_nxt);
	end

	genvar gi;
	generate
		for (gi = 0; gi < csl_pkg::STRAP_NUM; gi++)
		begin : g_dual
			// Each pin turns to an output on the capture edge and stays low
			// until the power-up timer has run out
			assign dual_oe_nxt[gi] = csl_latched(st_nxt);
			assign dual_out_nxt[gi] = csl_running(st_nxt) ? dual_ph_nxt : 1'b0;
		end
	endgenerate

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			clk_r <= '0;
			dual_oe_r <= '0;
			dual_out_r <= '0;
			strap_valid_r <= 1'b0;
		end
		else
		begin
			clk_r <= clk_nxt;
			dual_oe_r <= dual_oe_nxt;
			dual_out_r <= dual_out_nxt;
			strap_valid_r <= strap_valid_nxt;
		end
	end

	assign clk_out_o = clk_r;
	assign dual_pin_o = dual_out_r;
	assign dual_pin_oe_o = dual_oe_r;
	assign strap_cfg_o = strap_r;
	assign strap_valid_o = strap_valid_r;

endmodule

/* test/csl_sva.sv */
/* Port checker for csl_top.
   Bound from the testbench top file. */
`timescale 1ns/10ps
module csl_sva
#(
	parameter int PWRUP_CYC = 20
)
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic cpu_halt_n_i,
	input wire logic pci_halt_n_i,
	input wire logic [csl_pkg::STRAP_NUM-1:0] dual_pin_o,
	input wire logic [csl_pkg::STRAP_NUM-1:0] dual_pin_oe_o,
	input wire logic [csl_pkg::STRAP_NUM-1:0] strap_cfg_o,
	input wire logic strap_valid_o,
	input wire csl_pkg::csl_clk_out_t clk_out_o
);
	int cnt_r;
	int cnt_nxt;
	// Saturates so the counter cannot wrap in long runs
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (strap_valid_o && cnt_r < PWRUP_CYC + 8)
			cnt_nxt = cnt_r + 1;
	end
	always_ff @(posedge clk_sys_i)
		cnt_r <= srst_i ? 0 : cnt_nxt;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	sequence s_pci_tail;
		clk_out_o.pci_clk[0] ##1 !clk_out_o.pci_clk[0];
	endsequence
	sequence s_free_period;
		##2 !clk_out_o.free_pci_clk ##2 clk_out_o.free_pci_clk;
	endsequence
	property p_cpu_stop;
		!cpu_halt_n_i [*3] |-> clk_out_o.cpu_clk == '0;
	endproperty
	a_cpu_stop: assert property (p_cpu_stop) else $error("cpu clocks not parked");
	property p_cpu_resume;
		$rose(cpu_halt_n_i) |-> ##[1:3] $rose(clk_out_o.cpu_clk[0]);
	endproperty
	a_cpu_resume: assert property (p_cpu_resume) else $error("cpu clocks late");
	property p_pci_stop;
		!pci_halt_n_i [*4] |-> clk_out_o.pci_clk == '0;
	endproperty
	a_pci_stop: assert property (p_pci_stop) else $error("pci clocks not parked");
	property p_pci_resume;
		$rose(pci_halt_n_i) |-> ##[1:4] $rose(clk_out_o.pci_clk[0]);
	endproperty
	a_pci_resume: assert property (p_pci_resume) else $error("pci clocks late");
	property p_cpu_full;
		$rose(clk_out_o.cpu_clk[0]) |=> !clk_out_o.cpu_clk[0];
	endproperty
	a_cpu_full: assert property (p_cpu_full) else $error("cpu pulse width");
	property p_pci_full;
		$rose(clk_out_o.pci_clk[0]) |=> s_pci_tail;
	endproperty
	a_pci_full: assert property (p_pci_full) else $error("pci pulse width");
	property p_free_run;
		$rose(clk_out_o.free_pci_clk) |-> s_free_period;
	endproperty
	a_free_run: assert property (p_free_run) else $error("free clock stalled");
	property p_pair;
		(&clk_out_o.cpu_clk == |clk_out_o.cpu_clk) && (&clk_out_o.pci_clk == |clk_out_o.pci_clk);
	endproperty
	a_pair: assert property (p_pair) else $error("group bits differ");
	property p_strap_hold;
		strap_valid_o |=> strap_valid_o && $stable(strap_cfg_o) && dual_pin_oe_o == '1;
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("straps changed");
	property p_no_drive;
		!strap_valid_o |-> dual_pin_oe_o == '0;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("pins driven early");
	property p_dual_quiet;
		cnt_r < PWRUP_CYC + 4 |-> dual_pin_o == '0;
	endproperty
	a_dual_quiet: assert property (p_dual_quiet) else $error("dual pins early");
	property p_dual_start;
		cnt_r == PWRUP_CYC + 5 |-> dual_pin_o != '0;
	endproperty
	a_dual_start: assert property (p_dual_start) else $error("dual pins idle");
endmodule

/* test/csl_ctl_model.sv */
/* Power management controller model driving the halt inputs.
   Assumes the free PCI clock of the block under test. */
`timescale 1ns/10ps
module csl_ctl_model
(
	input wire logic free_pci_clk_i,
	input wire logic cpu_stop_req_i,
	input wire logic pci_stop_req_i,
	output logic cpu_halt_n_o,
	output logic pci_halt_n_o
);
	initial
	begin
		cpu_halt_n_o = 1'b1;
		pci_halt_n_o = 1'b1;
	end
	// Requests reach the pins only just after a free clock rise
	always @(posedge free_pci_clk_i)
	begin
		cpu_halt_n_o <= #1 !cpu_stop_req_i;
		pci_halt_n_o <= #1 !pci_stop_req_i;
	end
endmodule

/* test/csl_top_test.sv */
/* Self-checking bench for csl_top with a controller model.
   Assumes a short power-up timer. */
`timescale 1ns/10ps
module csl_top_test;
	localparam int PWRUP_CYC = 20;
	localparam logic [31:0] CPU_N = 16 / csl_pkg::CPU_HALF_CYC;
	localparam logic [31:0] PCI_N = 16 / csl_pkg::PCI_HALF_CYC;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic cpu_stop_req = 1'b0;
	logic pci_stop_req = 1'b0;
	logic cpu_halt_n;
	logic pci_halt_n;
	logic [4:0] strap_drv = 5'h15;
	logic [4:0] dual_pin, dual_out, dual_oe, strap_cfg;
	logic strap_valid;
	csl_pkg::csl_clk_out_t clk_out;
	int mismatches = 0;
	int checks_done = 0;
	always #5 clk_sys_i = !clk_sys_i;
	// Pin level resolved from the block's drive and the strap resistors
	assign dual_pin = (dual_oe & dual_out) | (~dual_oe & strap_drv);
	csl_top #(.PWRUP_CYC(PWRUP_CYC)) csl_top_inst
	(
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.cpu_halt_n_i(cpu_halt_n),
		.pci_halt_n_i(pci_halt_n),
		.dual_pin_i(dual_pin),
		.dual_pin_o(dual_out),
		.dual_pin_oe_o(dual_oe),
		.strap_cfg_o(strap_cfg),
		.strap_valid_o(strap_valid),
		.clk_out_o(clk_out)
	);
	csl_ctl_model csl_ctl_model_inst
	(
		.free_pci_clk_i(clk_out.free_pci_clk),
		.cpu_stop_req_i(cpu_stop_req),
		.pci_stop_req_i(pci_stop_req),
		.cpu_halt_n_o(cpu_halt_n),
		.pci_halt_n_o(pci_halt_n)
	);
	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task summarize;
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Counts bit 0 changes of each group over n cycles
	task watch(input int n, output int c, output int p, output int f);
		csl_pkg::csl_clk_out_t prev;
		c = 0;
		p = 0;
		f = 0;
		repeat (n)
		begin
			prev = clk_out;
			cyc(1);
			c += int'(clk_out.cpu_clk[0] !== prev.cpu_clk[0]);
			p += int'(clk_out.pci_clk[0] !== prev.pci_clk[0]);
			f += int'(clk_out.free_pci_clk !== prev.free_pci_clk);
		end
	endtask
	task t_strap;
		for (int i = 0; i < 20 && strap_valid !== 1'b1; i++)
			cyc(1);
		chk("strap_valid", 32'h1, strap_valid);
		chk("strap_cfg", 32'h15, strap_cfg);
		chk("dual_oe", 32'h1F, dual_oe);
		chk("dual_out", 32'h0, dual_out);
		strap_drv = 5'h0A;
		cyc(4);
		chk("strap_hold", 32'h15, strap_cfg);
	endtask
	task t_cpu_halt;
		int c, p, f;
		cpu_stop_req = 1'b1;
		cyc(16);
		watch(16, c, p, f);
		chk("cpu_toggles", 32'h0, c);
		chk("cpu_level", 32'h0, clk_out.cpu_clk);
		chk("pci_toggles", PCI_N, p);
		chk("free_toggles", PCI_N, f);
		cpu_stop_req = 1'b0;
		cyc(16);
		watch(16, c, p, f);
		chk("cpu_resumed", CPU_N, c);
	endtask
	task t_pci_halt;
		int c, p, f;
		pci_stop_req = 1'b1;
		cyc(16);
		watch(16, c, p, f);
		chk("pci_toggles", 32'h0, p);
		chk("pci_level", 32'h0, clk_out.pci_clk);
		chk("cpu_toggles", CPU_N, c);
		chk("free_toggles", PCI_N, f);
		pci_stop_req = 1'b0;
		cyc(16);
		watch(16, c, p, f);
		chk("pci_resumed", PCI_N, p);
	endtask
	task t_dual;
		int n;
		logic [4:0] prev;
		n = 0;
		repeat (16)
		begin
			prev = dual_out;
			cyc(1);
			n += int'(dual_out[0] !== prev[0]);
		end
		chk("dual_toggles", 16 / csl_pkg::DUAL_HALF_CYC, n);
	endtask
	initial
	begin
		cyc(20);
		srst_i = 1'b0;
		t_strap;
		t_cpu_halt;
		t_pci_halt;
		t_dual;
		summarize;
	end
	initial
	begin
		cyc(1000);
		mismatches++;
		summarize;
	end
endmodule
bind csl_top csl_sva #(.PWRUP_CYC(PWRUP_CYC)) csl_sva_inst
(
	.clk_sys_i(clk_sys_i),
	.srst_i(srst_i),
	.cpu_halt_n_i(cpu_halt_n_i),
	.pci_halt_n_i(pci_halt_n_i),
	.dual_pin_o(dual_pin_o),
	.dual_pin_oe_o(dual_pin_oe_o),
	.strap_cfg_o(strap_cfg_o),
	.strap_valid_o(strap_valid_o),
	.clk_out_o(clk_out_o)
);
